// >>> mdmac_control.sv
// multiply, multiply-accumulate and divide unit with its control register
`timescale 1ns/10ps
`include "mdmac_defines.svh"

module mdmac_control
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [2:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  output logic             DIVIDE_DONE_IRQ
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  mdmac_pkg::mdmac_bus_type   bus;
  mdmac_pkg::mdmac_mode_type  mode_reg;
  mdmac_pkg::mdmac_mode_type  mode_next;
  mdmac_pkg::mdmac_state_type state_reg;
  mdmac_pkg::mdmac_state_type state_next;

  logic [15:0] operand_a_low;
  logic [15:0] operand_a_high;
  logic [15:0] divisor_reg;
  logic [31:0] result_reg;
  logic [15:0] remain_reg;
  logic        a_low_seen_reg;
  logic        a_high_seen_reg;
  logic        divide_start_busy;
  logic        accum_overflow_flag;
  logic        accum_sign_flag;
  logic [15:0] rdata_reg;
  logic        irq_reg;
  logic [31:0] quo_reg;
  logic [15:0] rem_reg;
  logic [5:0]  cnt_reg;

  logic        wr_ctrl;
  logic        wr_a_low;
  logic        wr_a_high;
  logic        mode_legal;
  logic        mode_is_div;
  logic        start_div;
  logic        mul_go;
  logic        div_last;
  logic [31:0] product;
  logic [32:0] usum;
  logic [31:0] accum_sum;
  logic        ovf_now;
  logic [16:0] trial;
  logic [16:0] trial_diff;
  logic        trial_fits;
  logic [15:0] ctrl_view;

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  assign bus.addr  = REG_ADDR;
  assign bus.wdata = REG_WDATA;
  assign bus.wr    = REG_WR;
  assign bus.rd    = REG_RD;

  assign wr_ctrl   = bus.wr && (bus.addr == `MDMAC_ADDR_CTRL);
  assign wr_a_low  = bus.wr && (bus.addr == `MDMAC_ADDR_A_LOW);
  assign wr_a_high = bus.wr && (bus.addr == `MDMAC_ADDR_A_HIGH);

  // ****************************************************************
  // mode selection
  // ****************************************************************
  assign mode_next.divide_select     = bus.wdata[`MDMAC_BIT_DIVSEL];
  assign mode_next.accumulate_select = bus.wdata[`MDMAC_BIT_ACCSEL];
  assign mode_next.signed_select     = bus.wdata[`MDMAC_BIT_SGNSEL];

  // division allows only the unsigned form, with or without the done request
  assign mode_legal = !(mode_next.divide_select && mode_next.signed_select);
  assign mode_is_div = mode_next.divide_select && mode_legal;

  // a write during a running division keeps the mode to protect the result
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_reg <= `MDMAC_CTRL_RESET;
    end
    else if (wr_ctrl && mode_legal && !divide_start_busy)
    begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // operand registers and automatic multiply start
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      operand_a_low  <= `MDMAC_ZERO16;
      operand_a_high <= `MDMAC_ZERO16;
      divisor_reg    <= `MDMAC_ZERO16;
    end
    else if (bus.wr)
    begin
      if (bus.addr == `MDMAC_ADDR_A_LOW)
      begin
        operand_a_low <= bus.wdata;
      end
      if (bus.addr == `MDMAC_ADDR_A_HIGH)
      begin
        operand_a_high <= bus.wdata;
      end
      if (bus.addr == `MDMAC_ADDR_DVSR)
      begin
        divisor_reg <= bus.wdata;
      end
    end
  end

  // both halves must be written since the last product
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      a_low_seen_reg  <= 1'b0;
      a_high_seen_reg <= 1'b0;
    end
    else if (mul_go)
    begin
      // a half written in the product cycle counts for the next product
      a_low_seen_reg  <= wr_a_low;
      a_high_seen_reg <= wr_a_high;
    end
    else if (!mode_reg.divide_select)
    begin
      if (wr_a_low)
      begin
        a_low_seen_reg <= 1'b1;
      end
      if (wr_a_high)
      begin
        a_high_seen_reg <= 1'b1;
      end
    end
  end

  assign mul_go = (state_reg == mdmac_pkg::ST_MUL);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  assign start_div = wr_ctrl && bus.wdata[`MDMAC_BIT_START] && mode_is_div
                     && !divide_start_busy;
  assign div_last  = (cnt_reg == `MDMAC_DIV_STEPS - `MDMAC_CNT_W'(1));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      mdmac_pkg::ST_IDLE:
      begin
        if (start_div)
        begin
          state_next = mdmac_pkg::ST_DIV;
        end
        else if (!mode_reg.divide_select && a_low_seen_reg && a_high_seen_reg)
        begin
          state_next = mdmac_pkg::ST_MUL;
        end
      end
      mdmac_pkg::ST_MUL:
      begin
        state_next = mdmac_pkg::ST_IDLE;
      end
      mdmac_pkg::ST_DIV:
      begin
        if (div_last)
        begin
          state_next = mdmac_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = mdmac_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= mdmac_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // division start and busy bit
  // ****************************************************************
  // zero writes while running are ignored; the end of the run clears the bit
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      divide_start_busy <= 1'b0;
    end
    else if (start_div)
    begin
      divide_start_busy <= 1'b1;
    end
    else if (divide_start_busy && div_last)
    begin
      divide_start_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // restoring divider, one quotient bit per clock
  // ****************************************************************
  assign trial      = {rem_reg, quo_reg[31]};
  assign trial_diff = trial - {1'b0, divisor_reg};
  assign trial_fits = (trial >= {1'b0, divisor_reg});

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      quo_reg <= `MDMAC_ZERO32;
      rem_reg <= `MDMAC_ZERO16;
      cnt_reg <= `MDMAC_CNT_W'(0);
    end
    else if (start_div)
    begin
      quo_reg <= {operand_a_high, operand_a_low};
      rem_reg <= `MDMAC_ZERO16;
      cnt_reg <= `MDMAC_CNT_W'(0);
    end
    else if (state_reg == mdmac_pkg::ST_DIV)
    begin
      quo_reg <= {quo_reg[30:0], trial_fits};
      rem_reg <= trial_fits ? trial_diff[15:0] : trial[15:0];
      cnt_reg <= cnt_reg + `MDMAC_CNT_W'(1);
    end
  end

  // ****************************************************************
  // multiply and accumulate
  // ****************************************************************
  always_comb
  begin
    if (mode_reg.signed_select)
    begin
      product = 32'($signed(operand_a_high)) * 32'($signed(operand_a_low));
    end
    else
    begin
      product = 32'(operand_a_high) * 32'(operand_a_low);
    end
  end

  assign usum      = {1'b0, result_reg} + {1'b0, product};
  assign accum_sum = usum[31:0];

  always_comb
  begin
    if (mode_reg.signed_select)
    begin
      // operands of equal sign giving a result of the other sign
      ovf_now = (!result_reg[31] && !product[31] && accum_sum[31])
             || (result_reg[31] && product[31] && !accum_sum[31]);
    end
    else
    begin
      ovf_now = usum[32];
    end
  end

  // each accumulation reports its own overflow
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      accum_overflow_flag <= 1'b0;
    end
    else if (mul_go && mode_reg.accumulate_select)
    begin
      accum_overflow_flag <= ovf_now;
    end
  end

  always_comb
  begin
    if (mode_reg.accumulate_select && mode_reg.signed_select && !mode_reg.divide_select)
    begin
      accum_sign_flag = result_reg[31];
    end
    else
    begin
      accum_sign_flag = 1'b0;
    end
  end

  // ****************************************************************
  // result and remainder
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      result_reg <= `MDMAC_ZERO32;
    end
    else if (mul_go)
    begin
      result_reg <= mode_reg.accumulate_select ? accum_sum : product;
    end
    else if (state_reg == mdmac_pkg::ST_DIV && div_last)
    begin
      result_reg <= {quo_reg[30:0], trial_fits};
    end
    else if (bus.wr && bus.addr == `MDMAC_ADDR_RES_LOW)
    begin
      result_reg[15:0] <= bus.wdata;
    end
    else if (bus.wr && bus.addr == `MDMAC_ADDR_RES_HIGH)
    begin
      result_reg[31:16] <= bus.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      remain_reg <= `MDMAC_ZERO16;
    end
    else if (state_reg == mdmac_pkg::ST_DIV && div_last)
    begin
      remain_reg <= trial_fits ? trial_diff[15:0] : trial[15:0];
    end
  end

  // ****************************************************************
  // division done request
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= divide_start_busy && div_last
                 && !mode_reg.accumulate_select;
    end
  end

  assign DIVIDE_DONE_IRQ = irq_reg;

  // ****************************************************************
  // read port
  // ****************************************************************
  // flag bits come from hardware only, never from write data
  always_comb
  begin
    ctrl_view                       = `MDMAC_ZERO16;
    ctrl_view[`MDMAC_BIT_DIVSEL]    = mode_reg.divide_select;
    ctrl_view[`MDMAC_BIT_ACCSEL]    = mode_reg.accumulate_select;
    ctrl_view[`MDMAC_BIT_SGNSEL]    = mode_reg.signed_select;
    ctrl_view[`MDMAC_BIT_OVF]       = accum_overflow_flag;
    ctrl_view[`MDMAC_BIT_SIGN]      = accum_sign_flag;
    ctrl_view[`MDMAC_BIT_START]     = divide_start_busy;
  end

  // data stand for one cycle after the strobe and read zero otherwise
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_reg <= `MDMAC_ZERO16;
    end
    else if (bus.rd)
    begin
      unique case (bus.addr)
        `MDMAC_ADDR_CTRL:     rdata_reg <= ctrl_view;
        `MDMAC_ADDR_A_LOW:    rdata_reg <= operand_a_low;
        `MDMAC_ADDR_A_HIGH:   rdata_reg <= operand_a_high;
        `MDMAC_ADDR_DVSR:     rdata_reg <= divisor_reg;
        `MDMAC_ADDR_RES_LOW:  rdata_reg <= result_reg[15:0];
        `MDMAC_ADDR_RES_HIGH: rdata_reg <= result_reg[31:16];
        `MDMAC_ADDR_REMAIN:   rdata_reg <= remain_reg;
        default:              rdata_reg <= `MDMAC_ZERO16;
      endcase
    end
    else
    begin
      rdata_reg <= `MDMAC_ZERO16;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule : mdmac_control

// >>> mdmac_control_bench.sv
// self-checking bench of the multiply, accumulate and divide control block
`timescale 1ns/10ps
module mdmac_control_bench;
  logic        sys_clk;
  logic        rst;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        divide_done_irq;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cycles    = 0;
  localparam logic [15:0] mode_codes [6] = '{16'h0000, 16'h0008, 16'h0040, 16'h0048,
                                             16'h0080, 16'h00c0};

  mdmac_control u_mdmac_control
  (
    .SYS_CLK         (sys_clk),
    .RST             (rst),
    .REG_ADDR        (reg_addr),
    .REG_WDATA       (reg_wdata),
    .REG_WR          (reg_wr),
    .REG_RD          (reg_rd),
    .REG_RDATA       (reg_rdata),
    .DIVIDE_DONE_IRQ (divide_done_irq)
  );

  // ****************************************************************
  // clock, watchdog and bus tasks
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask : rd

  // preset the accumulator, load both operand halves, check result and flags
  task automatic mac_step(input logic [15:0] ph, pl, ma, mb, rh, rl, ctl);
    wr(3'h5, ph);
    wr(3'h4, pl);
    wr(3'h1, ma);
    wr(3'h2, mb);
    // the product lands two edges after the second half is taken
    @(posedge sys_clk);
    rd(3'h4, rl);
    rd(3'h5, rh);
    rd(3'h0, ctl);
  endtask : mac_step

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_modes();
    rd(3'h0, 16'h0000);
    foreach (mode_codes[i])
    begin
      wr(3'h0, mode_codes[i]);
      rd(3'h0, mode_codes[i]);
    end
    wr(3'h0, 16'h0088);
    rd(3'h0, 16'h00c0);
    wr(3'h0, 16'h000f);
    rd(3'h0, 16'h0008);
    wr(3'h7, 16'hffff);
    rd(3'h7, 16'h0000);
  endtask : t_modes

  task automatic t_mul_mac();
    wr(3'h0, 16'h0000);
    mac_step(16'hffff, 16'hffff, 16'h1234, 16'h0010, 16'h0001, 16'h2340, 16'h0000);
    wr(3'h0, 16'h0008);
    mac_step(16'h0000, 16'h0000, 16'hffff, 16'h0002, 16'hffff, 16'hfffe, 16'h0008);
    wr(3'h0, 16'h0040);
    mac_step(16'hffff, 16'hffff, 16'h0002, 16'h0001, 16'h0000, 16'h0001, 16'h0044);
    mac_step(16'h7fff, 16'hffff, 16'h0001, 16'h0001, 16'h8000, 16'h0000, 16'h0040);
    wr(3'h0, 16'h0048);
    mac_step(16'h7fff, 16'hffff, 16'h0001, 16'h0001, 16'h8000, 16'h0000, 16'h004e);
    mac_step(16'h8000, 16'h0000, 16'hffff, 16'h0001, 16'h7fff, 16'hffff, 16'h004c);
    mac_step(16'h0000, 16'h0000, 16'hffff, 16'h0001, 16'hffff, 16'hffff, 16'h004a);
  endtask : t_mul_mac

  task automatic t_div_irq();
    int n;
    wr(3'h0, 16'h0080);
    wr(3'h1, 16'h0005);
    wr(3'h2, 16'h0001);
    wr(3'h3, 16'h0010);
    wr(3'h0, 16'h0081);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    while (divide_done_irq !== 1'b1 && n < 40);
    chk(16'(n), 16'h0021);
    @(negedge sys_clk);
    chk({15'h0000, divide_done_irq}, 16'h0000);
    rd(3'h4, 16'h1000);
    rd(3'h5, 16'h0000);
    rd(3'h6, 16'h0005);
    rd(3'h0, 16'h0080);
  endtask : t_div_irq

  task automatic t_div_busy();
    logic seen;
    seen = 1'b0;
    wr(3'h0, 16'h00c0);
    wr(3'h0, 16'h00c1);
    rd(3'h0, 16'h00c1);
    wr(3'h0, 16'h00c0);
    rd(3'h0, 16'h00c1);
    repeat (40)
    begin
      @(negedge sys_clk);
      seen = seen | divide_done_irq;
    end
    chk({15'h0000, seen}, 16'h0000);
    rd(3'h0, 16'h00c0);
  endtask : t_div_busy

  task automatic t_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(3'h0, 16'h0000);
    rd(3'h4, 16'h0000);
  endtask : t_reset

  initial
  begin
    rst       = 1'b1;
    reg_addr  = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_modes();
    t_mul_mac();
    t_div_irq();
    t_div_busy();
    t_reset();
    close_out();
  end
endmodule : mdmac_control_bench

// >>> mdmac_control_checker.sv
// port checker of the multiply, accumulate and divide control block
`timescale 1ns/10ps
module mdmac_checker
(
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [2:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        DIVIDE_DONE_IRQ
);
  logic [5:0] div_cnt_reg;
  logic       irq_mode_reg;
  logic       ctl_rd;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  assign ctl_rd = REG_RD && (REG_ADDR == 3'h0);

  // ****************************************************************
  // shadow of the division sequencer
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      div_cnt_reg  <= 6'h00;
      irq_mode_reg <= 1'b0;
    end
    else if (div_cnt_reg != 6'h00)
      div_cnt_reg <= div_cnt_reg - 6'h01;
    else if (REG_WR && REG_ADDR == 3'h0 && REG_WDATA[7] && !REG_WDATA[3] && REG_WDATA[0])
    begin
      div_cnt_reg  <= 6'h20;
      irq_mode_reg <= !REG_WDATA[6];
    end
  end

  a_rdata_idle_zero: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data not zero outside read answer");
  a_unmapped_read_zero: assert property (REG_RD && REG_ADDR == 3'h7 |=> REG_RDATA == 16'h0000)
    else $error("unmapped index returned data");
  a_start_div_only: assert property (ctl_rd |=> !REG_RDATA[0] || REG_RDATA[7])
    else $error("start bit set outside division mode");
  a_sign_flag_zero: assert property (ctl_rd |=> !REG_RDATA[1] || (REG_RDATA[6] && REG_RDATA[3]))
    else $error("sign flag set outside signed accumulate");
  a_ctrl_unused_zero: assert property (ctl_rd |=> REG_RDATA[15:8] == 8'h00 && REG_RDATA[5:4] == 2'h0)
    else $error("unused control bits not zero");
  a_busy_reads_one: assert property (ctl_rd && div_cnt_reg > 6'h01 |=> REG_RDATA[0])
    else $error("busy bit low during division");
  a_busy_clears: assert property (ctl_rd && div_cnt_reg == 6'h00 |=> !REG_RDATA[0])
    else $error("busy bit high after division");
  a_irq_at_end: assert property (div_cnt_reg == 6'h01 && irq_mode_reg |=> DIVIDE_DONE_IRQ)
    else $error("missing division done request");
  a_irq_has_cause: assert property (DIVIDE_DONE_IRQ |-> $past(div_cnt_reg) == 6'h01 && $past(irq_mode_reg))
    else $error("division done request without cause");
  a_irq_one_cycle: assert property (DIVIDE_DONE_IRQ |=> !DIVIDE_DONE_IRQ)
    else $error("division done request longer than one cycle");

  c_irq_seen: cover property (DIVIDE_DONE_IRQ);
  c_busy_read: cover property (ctl_rd && div_cnt_reg > 6'h01);
  c_unmapped_read: cover property (REG_RD && REG_ADDR == 3'h7);
endmodule : mdmac_checker

bind mdmac_control mdmac_checker u_mdmac_checker
(
  .SYS_CLK         (SYS_CLK),
  .RST             (RST),
  .REG_ADDR        (REG_ADDR),
  .REG_WDATA       (REG_WDATA),
  .REG_WR          (REG_WR),
  .REG_RD          (REG_RD),
  .REG_RDATA       (REG_RDATA),
  .DIVIDE_DONE_IRQ (DIVIDE_DONE_IRQ)
);

// >>> mdmac_defines.svh
// constants of the multiply, multiply-accumulate and divide control block
// Summary of operation
// - unsigned accumulate outside 32-bit range sets overflow
// - signed positive plus positive turning negative overflows
// - signed negative plus negative turning positive overflows
// - unsigned accumulate mode reports sign flag zero
// - signed accumulate sign flag is accumulator bit 31
// - start bit accepts one only in division mode
// - start bit begins division, reads one while running
// - start bit clears itself when division ends
// - multiply starts once both operand halves written
// - writing zero during division leaves start bit set
// - control bits one and two are read-only
// - three mode bits select six legal operations
// - control register resets to zero, unsigned multiply
`ifndef MDMAC_DEFINES_SVH
`define MDMAC_DEFINES_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define MDMAC_ADDR_W        3
`define MDMAC_DATA_W        16
`define MDMAC_ADDR_CTRL     3'h0
`define MDMAC_ADDR_A_LOW    3'h1
`define MDMAC_ADDR_A_HIGH   3'h2
`define MDMAC_ADDR_DVSR     3'h3
`define MDMAC_ADDR_RES_LOW  3'h4
`define MDMAC_ADDR_RES_HIGH 3'h5
`define MDMAC_ADDR_REMAIN   3'h6

// ****************************************************************
// control register fields
// ****************************************************************
`define MDMAC_BIT_DIVSEL    7
`define MDMAC_BIT_ACCSEL    6
`define MDMAC_BIT_SGNSEL    3
`define MDMAC_BIT_OVF       2
`define MDMAC_BIT_SIGN      1
`define MDMAC_BIT_START     0
`define MDMAC_CTRL_RESET    3'h0
`define MDMAC_ZERO16        16'h0000
`define MDMAC_ZERO32        32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define MDMAC_DIV_STEPS     6'h20
`define MDMAC_CNT_W         6

`endif

// >>> mdmac_pkg.sv
// types of the multiply, multiply-accumulate and divide control block
package mdmac_pkg;

  typedef struct packed {
    logic divide_select;
    logic accumulate_select;
    logic signed_select;
  } mdmac_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MUL  = 2'b01,
    ST_DIV  = 2'b10
  } mdmac_state_type;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mdmac_bus_type;

endpackage : mdmac_pkg
